// ---- hdl/tbd_map.svh ----
`ifndef TBD_MAP_SVH
`define TBD_MAP_SVH
// timing of the blink code and of the two flashers, in microseconds as figures of our own choosing
`define TBD_CLK_MHZ 100
`define TBD_PULSE_ON_US 250000
`define TBD_PULSE_OFF_US 250000
`define TBD_GROUP_PAUSE_US 1000000
`define TBD_CODE_PAUSE_US 2000000
`define TBD_EMC_HALF_US 50000
`define TBD_ACT_HALF_US 50000
// derived cycle counts
`define TBD_PULSE_ON_CYC (`TBD_PULSE_ON_US * `TBD_CLK_MHZ)
`define TBD_PULSE_OFF_CYC (`TBD_PULSE_OFF_US * `TBD_CLK_MHZ)
`define TBD_GROUP_PAUSE_CYC (`TBD_GROUP_PAUSE_US * `TBD_CLK_MHZ)
`define TBD_CODE_PAUSE_CYC (`TBD_CODE_PAUSE_US * `TBD_CLK_MHZ)
`define TBD_EMC_HALF_CYC (`TBD_EMC_HALF_US * `TBD_CLK_MHZ)
`define TBD_ACT_HALF_CYC (`TBD_ACT_HALF_US * `TBD_CLK_MHZ)
// fault classes, as pulse counts
`define TBD_CLS_CMD 4'h3
`define TBD_CLS_DATA 4'h4
`define TBD_CLS_REG 4'h5
`define TBD_CLS_INIT 4'h6
`define TBD_CLS_LEN 4'h7
// fault codes at the input port
`define TBD_F_NONE 3'h0
`define TBD_F_CMD 3'h1
`define TBD_F_BREAK 3'h2
`define TBD_F_REG 3'h3
`define TBD_F_INIT 3'h4
`define TBD_F_INTERNAL 3'h5
`define TBD_F_LEN 3'h6
`define TBD_F_RESET 3'h7
`endif

// ---- hdl/tbd_pkg.sv ----
package tbd_pkg;
  typedef enum logic [2:0] {
    TBD_IDLE,
    TBD_CLS_ON,
    TBD_CLS_OFF,
    TBD_GAP,
    TBD_ARG_ON,
    TBD_ARG_OFF,
    TBD_TAIL
  } tbd_seq_t;
endpackage

// ---- hdl/tbd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser with agreement of stages two and three
module tbd_sync (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic [2:0] sh;
    logic q;
  } tbd_sync_st_t;
  tbd_sync_st_t s_r;
  tbd_sync_st_t s_nxt;
  // shift, take change once stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.sh = {s_r.sh[1:0], i_d};
    if (s_r.sh[1] == s_r.sh[2]) begin
      s_nxt.q = s_r.sh[2];
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_q = s_r.q;
endmodule
`default_nettype wire

// ---- hdl/tbd_blink.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbd_map.svh"
// free-running square wave, held low while disabled
module tbd_blink #(
  parameter int unsigned HALF_CYC = 5000000
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  output logic o_wave
);
  typedef struct packed {
    logic [31:0] cnt;
    logic wave;
  } tbd_blink_st_t;
  tbd_blink_st_t s_r;
  tbd_blink_st_t s_nxt;
  // count half periods and toggle
  always_comb begin
    s_nxt = s_r;
    if (!i_en) begin
      s_nxt = '0;
    end else if (s_r.cnt >= 32'(HALF_CYC - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.wave = ~s_r.wave;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_wave = s_r.wave;
endmodule
`default_nettype wire

// ---- hdl/tbd_led.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbd_map.svh"
// Functional notes
// R1 - the link/activity led flashes green while fieldbus traffic is active.
// R2 - the run led is steady green while the terminal bus cycles with no fault.
// R3 - the error led lights red on any fault and shows its identity as a blink code.
// R4 - an interference fault gives continuous flashing with no countable group.
// R5 - a command error gives three pulses with argument zero.
// R6 - a break right behind the coupler gives four pulses with argument zero.
// R7 - a break behind terminal n gives four pulses with argument n.
// R8 - a register communication failure with terminal n gives five pulses with argument n.
// R9 - init failure gives six pulses argument zero, internal data error six pulses argument one or eight.
// R10 - a process-data length mismatch gives seven pulses with argument zero.
// R11 - a failed bus reset gives seven pulses with a nonzero argument.
// R12 - a restart clears the fault state so only remaining faults are shown afterwards.
// R13 - the sequence is class group, pause, argument group, repeated while the fault stays.
// R14 - pulse and pause times come from parameterised dividers and all counters clear on reset.
module tbd_led #(
  parameter int unsigned PULSE_ON_CYC = `TBD_PULSE_ON_CYC,
  parameter int unsigned PULSE_OFF_CYC = `TBD_PULSE_OFF_CYC,
  parameter int unsigned GROUP_PAUSE_CYC = `TBD_GROUP_PAUSE_CYC,
  parameter int unsigned CODE_PAUSE_CYC = `TBD_CODE_PAUSE_CYC,
  parameter int unsigned EMC_HALF_CYC = `TBD_EMC_HALF_CYC,
  parameter int unsigned ACT_HALF_CYC = `TBD_ACT_HALF_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_fb_activity,
  input wire logic i_tb_running,
  input wire logic i_emc_fault,
  input wire logic [2:0] i_fault_code,
  input wire logic [7:0] i_fault_arg,
  input wire logic i_restart,
  output logic o_link_led,
  output logic o_run_led,
  output logic o_err_led
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic act_s;
  logic emc_s;
  tbd_sync u_sync_act (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_d(i_fb_activity),
    .o_q(act_s)
  );
  tbd_sync u_sync_emc (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_d(i_emc_fault),
    .o_q(emc_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flashers for activity and interference
  logic act_wave;
  logic emc_wave;
  tbd_blink #(.HALF_CYC(ACT_HALF_CYC)) u_blink_act (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_en(act_s),
    .o_wave(act_wave)
  );
  tbd_blink #(.HALF_CYC(EMC_HALF_CYC)) u_blink_emc (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_en(emc_s),
    .o_wave(emc_wave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fault decode into class and argument
  logic [3:0] cls;
  logic [7:0] arg;
  logic fault;
  always_comb begin
    cls = 4'h0;
    arg = 8'h00;
    case (i_fault_code)
      `TBD_F_CMD: begin
        cls = `TBD_CLS_CMD; // R5
      end
      `TBD_F_BREAK: begin
        cls = `TBD_CLS_DATA; // R6
        arg = i_fault_arg; // R7
      end
      `TBD_F_REG: begin
        cls = `TBD_CLS_REG; // R8
        arg = i_fault_arg;
      end
      `TBD_F_INIT: begin
        cls = `TBD_CLS_INIT; // R9
      end
      `TBD_F_INTERNAL: begin
        cls = `TBD_CLS_INIT; // R9
        arg = i_fault_arg[3] ? 8'h08 : 8'h01;
      end
      `TBD_F_LEN: begin
        cls = `TBD_CLS_LEN; // R10
      end
      `TBD_F_RESET: begin
        cls = `TBD_CLS_LEN; // R11
        arg = (i_fault_arg == 8'h00) ? 8'h01 : i_fault_arg;
      end
      default: begin
        cls = 4'h0;
      end
    endcase
    fault = (cls != 4'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink code sequencer state
  typedef struct packed {
    tbd_pkg::tbd_seq_t st;
    logic [31:0] tmr;
    logic [7:0] left;
    logic [3:0] cls;
    logic [7:0] arg;
    logic led;
    logic link;
    logic run;
    logic err;
  } tbd_led_st_t;
  tbd_led_st_t s_r;
  tbd_led_st_t s_nxt;
  logic tmr_done;
  assign tmr_done = (s_r.tmr == 32'h0);

  // class group, pause, argument group, long pause, repeat
  always_comb begin
    s_nxt = s_r;
    if (!tmr_done) begin
      s_nxt.tmr = s_r.tmr - 32'h1; // R14
    end
    if (i_restart || !fault) begin
      s_nxt.st = tbd_pkg::TBD_IDLE; // R12
      s_nxt.tmr = '0;
      s_nxt.left = '0;
      s_nxt.led = 1'b0;
    end else begin
      case (s_r.st)
        tbd_pkg::TBD_IDLE: begin
          s_nxt.cls = cls; // R13
          s_nxt.arg = arg;
          s_nxt.left = {4'h0, cls};
          s_nxt.st = tbd_pkg::TBD_CLS_ON;
          s_nxt.tmr = 32'(PULSE_ON_CYC - 1);
          s_nxt.led = 1'b1;
        end
        tbd_pkg::TBD_CLS_ON: begin
          if (tmr_done) begin
            s_nxt.led = 1'b0;
            s_nxt.left = s_r.left - 8'h1;
            if (s_r.left == 8'h1) begin
              s_nxt.st = tbd_pkg::TBD_GAP; // R13
              s_nxt.tmr = 32'(GROUP_PAUSE_CYC - 1);
            end else begin
              s_nxt.st = tbd_pkg::TBD_CLS_OFF;
              s_nxt.tmr = 32'(PULSE_OFF_CYC - 1);
            end
          end
        end
        tbd_pkg::TBD_CLS_OFF: begin
          if (tmr_done) begin
            s_nxt.st = tbd_pkg::TBD_CLS_ON;
            s_nxt.tmr = 32'(PULSE_ON_CYC - 1);
            s_nxt.led = 1'b1;
          end
        end
        tbd_pkg::TBD_GAP: begin
          if (tmr_done) begin
            s_nxt.left = s_r.arg;
            if (s_r.arg == 8'h0) begin
              s_nxt.st = tbd_pkg::TBD_TAIL; // argument zero shows no pulse
              s_nxt.tmr = 32'(CODE_PAUSE_CYC - 1);
            end else begin
              s_nxt.st = tbd_pkg::TBD_ARG_ON;
              s_nxt.tmr = 32'(PULSE_ON_CYC - 1);
              s_nxt.led = 1'b1;
            end
          end
        end
        tbd_pkg::TBD_ARG_ON: begin
          if (tmr_done) begin
            s_nxt.led = 1'b0;
            s_nxt.left = s_r.left - 8'h1;
            if (s_r.left == 8'h1) begin
              s_nxt.st = tbd_pkg::TBD_TAIL;
              s_nxt.tmr = 32'(CODE_PAUSE_CYC - 1);
            end else begin
              s_nxt.st = tbd_pkg::TBD_ARG_OFF;
              s_nxt.tmr = 32'(PULSE_OFF_CYC - 1);
            end
          end
        end
        tbd_pkg::TBD_ARG_OFF: begin
          if (tmr_done) begin
            s_nxt.st = tbd_pkg::TBD_ARG_ON;
            s_nxt.tmr = 32'(PULSE_ON_CYC - 1);
            s_nxt.led = 1'b1;
          end
        end
        tbd_pkg::TBD_TAIL: begin
          if (tmr_done) begin
            s_nxt.st = tbd_pkg::TBD_IDLE; // R13
          end
        end
        default: begin
          s_nxt.st = tbd_pkg::TBD_IDLE;
        end
      endcase
    end
    // led drivers, one cycle behind their sources
    s_nxt.link = act_wave; // R1
    s_nxt.run = i_tb_running && !fault && !emc_s; // R2
    s_nxt.err = emc_s ? emc_wave : s_r.led; // R3 R4
  end

  // state register, cleared on reset
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0; // R14
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // led outputs straight from the state register
  assign o_link_led = s_r.link;
  assign o_run_led = s_r.run;
  assign o_err_led = s_r.err;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_restart;
    i_restart;
  endsequence
  sequence seq_dark;
    !s_r.led ##1 (!o_err_led || $past(emc_s));
  endsequence
  sequence seq_gap_end;
    s_r.st == tbd_pkg::TBD_GAP && tmr_done && fault && !i_restart;
  endsequence
  sequence seq_take;
    s_r.st == tbd_pkg::TBD_IDLE && fault && !i_restart;
  endsequence

  AST_RUN_OFF_ON_FAULT: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R2
    fault |=> !o_run_led)
    else $error("run led lit during fault");
  AST_RUN_ON: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R2
    (i_tb_running && !fault && !emc_s) |=> o_run_led)
    else $error("run led dark while healthy");
  AST_ERR_FOLLOWS_SEQ: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R3
    !emc_s |=> (o_err_led == $past(s_r.led)))
    else $error("error led not following sequencer");
  AST_EMC_FLASH: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R4
    emc_s |=> (o_err_led == $past(emc_wave)))
    else $error("error led not flashing for interference");
  AST_CMD_CLASS: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R5
    (s_r.st == tbd_pkg::TBD_IDLE && i_fault_code == `TBD_F_CMD && !i_restart)
    |=> (s_r.left == 8'h3 && s_r.arg == 8'h0 && s_r.led))
    else $error("command error not three pulses arg zero");
  AST_BREAK_ARG: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R7
    (s_r.st == tbd_pkg::TBD_IDLE && i_fault_code == `TBD_F_BREAK && !i_restart)
    |=> (s_r.cls == 4'h4 && s_r.arg == $past(i_fault_arg)))
    else $error("break code wrong");
  AST_RESET_NONZERO: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R11
    (s_r.st == tbd_pkg::TBD_IDLE && i_fault_code == `TBD_F_RESET && !i_restart)
    |=> (s_r.cls == 4'h7 && s_r.arg != 8'h0))
    else $error("reset failure argument zero");
  AST_RESTART_CLEARS: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R12
    seq_restart |=> (s_r.st == tbd_pkg::TBD_IDLE) ##0 seq_dark)
    else $error("restart did not clear sequencer");
  AST_GAP_AFTER_CLASS: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R13
    (s_r.st == tbd_pkg::TBD_CLS_ON && tmr_done && s_r.left == 8'h1 && fault && !i_restart)
    |=> (s_r.st == tbd_pkg::TBD_GAP && !s_r.led))
    else $error("no pause after class group");
  AST_TIMER_DOWN: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R14
    (!tmr_done && fault && !i_restart && s_r.st != tbd_pkg::TBD_IDLE)
    |=> (s_r.tmr == $past(s_r.tmr) - 32'h1 || $past(tmr_done)))
    else $error("divider did not count down");
  AST_ARG_AFTER_GAP: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R13
    seq_gap_end ##0 (s_r.arg != 8'h00) |=> (s_r.st == tbd_pkg::TBD_ARG_ON && s_r.led))
    else $error("no argument group after pause");
  AST_ZERO_ARG_DARK: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R10
    seq_gap_end ##0 (s_r.arg == 8'h00) |=> (s_r.st == tbd_pkg::TBD_TAIL && !s_r.led))
    else $error("argument zero lit the led");
  AST_REG_CLASS: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R8
    seq_take ##0 (i_fault_code == `TBD_F_REG) |=> (s_r.cls == `TBD_CLS_REG && s_r.arg == $past(i_fault_arg)))
    else $error("register error code wrong");
  AST_INTERNAL_ARG: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R9
    seq_take ##0 (i_fault_code == `TBD_F_INTERNAL) |=> (s_r.cls == `TBD_CLS_INIT && (s_r.arg == 8'h01 || s_r.arg == 8'h08)))
    else $error("internal data error argument wrong");
  AST_LEN_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R10
    seq_take ##0 (i_fault_code == `TBD_F_LEN) |=> (s_r.cls == `TBD_CLS_LEN && s_r.arg == 8'h00))
    else $error("length mismatch argument not zero");
  AST_FAULT_GONE: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R3
    !fault |=> (s_r.st == tbd_pkg::TBD_IDLE && !s_r.led))
    else $error("sequencer kept running without a fault");
  AST_LINK_DARK: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R1
    !act_s |=> !act_wave)
    else $error("activity flash ran without traffic");
endmodule
`default_nettype wire

// ---- verification/tbd_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// terminal-bus master status; its levels change just after a rising edge
module tbd_model (
  input wire logic i_core_clk,
  output logic o_act,
  output logic o_run,
  output logic o_emc,
  output logic [2:0] o_code,
  output logic [7:0] o_arg,
  output logic o_restart
);
  // quiet bus after power-up
  initial begin
    o_act = 1'b0;
    o_run = 1'b0;
    o_emc = 1'b0;
    o_code = 3'h0;
    o_arg = 8'h00;
    o_restart = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // apply one status word at the next rising edge
  task automatic put(input logic a, input logic r, input logic e, input logic [2:0] c, input logic [7:0] n);
    @(posedge i_core_clk);
    o_act <= a;
    o_run <= r;
    o_emc <= e;
    o_code <= c;
    o_arg <= n;
  endtask

  // coupler restart level, bus init is re-run while it is high
  task automatic rst(input logic v);
    @(posedge i_core_clk);
    o_restart <= v;
  endtask
endmodule
`default_nettype wire

// ---- verification/terminal_bus_diag_led_encoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module terminal_bus_diag_led_encoder_tb;
  localparam int ON = 4;
  localparam int OFF = 4;
  localparam int GAP = 8;
  localparam int TAIL = 12;
  localparam int HALF = 3;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire logic act, run, emc, rstr, link, runl, err;
  wire logic [2:0] code;
  wire logic [7:0] arg;
  int n_fail = 0;
  int checks = 0;
  // code in, arg in, class pulses, arg pulses
  logic [22:0] tbl [10] = '{{3'h1, 8'h00, 4'h3, 8'h00}, {3'h2, 8'h00, 4'h4, 8'h00},
    {3'h2, 8'h05, 4'h4, 8'h05}, {3'h3, 8'h07, 4'h5, 8'h07}, {3'h4, 8'h00, 4'h6, 8'h00},
    {3'h5, 8'h00, 4'h6, 8'h01}, {3'h5, 8'h08, 4'h6, 8'h08}, {3'h6, 8'h00, 4'h7, 8'h00},
    {3'h7, 8'h00, 4'h7, 8'h01}, {3'h7, 8'h03, 4'h7, 8'h03}};

  // clock, 10 ns period
  always #5 clk = ~clk;

  tbd_model pm (.i_core_clk(clk), .o_act(act), .o_run(run), .o_emc(emc), .o_code(code), .o_arg(arg),
    .o_restart(rstr));
  tbd_led #(.PULSE_ON_CYC(ON), .PULSE_OFF_CYC(OFF), .GROUP_PAUSE_CYC(GAP), .CODE_PAUSE_CYC(TAIL),
    .EMC_HALF_CYC(HALF), .ACT_HALF_CYC(HALF)) uut (.i_core_clk(clk), .i_rstn(rstn),
    .i_fb_activity(act), .i_tb_running(run), .i_emc_fault(emc), .i_fault_code(code),
    .i_fault_arg(arg), .i_restart(rstr), .o_link_led(link), .o_run_led(runl), .o_err_led(err));

  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // wait at falling edges for a led level, then count how long it lasts
  task automatic run_len(input bit lnk, input logic lvl, input int lim, output int n);
    n = 0;
    while ((lnk ? link : err) !== lvl && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while ((lnk ? link : err) === lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // read one whole blink code from the error led
  task automatic capture(output int cls, output int ag);
    int n, g;
    cls = 0;
    ag = 0;
    g = 0;
    while (g < 2) begin
      run_len(1'b0, 1'b1, 50, n);
      cmp("pulse on", 8'(ON), 8'(n));
      if (g == 0) cls++;
      else ag++;
      run_len(1'b0, 1'b0, TAIL, n);
      if (n >= TAIL) g = 2;
      else if (n > OFF) begin
        g++;
        cmp("group pause", 8'(GAP), 8'(n));
      end else cmp("pulse off", 8'(OFF), 8'(n));
    end
  endtask

  ////////////////////////////////////////////////////////////
  // run led, and error led two cycles after a fault
  task automatic t_run;
    pm.put(1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
    repeat (3) @(negedge clk);
    cmp("run led", 8'h01, runl);
    cmp("err idle", 8'h00, err);
    pm.put(1'b0, 1'b1, 1'b0, 3'h1, 8'h00);
    repeat (2) @(negedge clk);
    cmp("err early", 8'h00, err);
    @(negedge clk);
    cmp("err lit", 8'h01, err);
    cmp("run off", 8'h00, runl);
  endtask

  // every fault code, each read twice in a row
  task automatic t_codes;
    int c, a;
    for (int i = 0; i < 10; i++) begin
      pm.put(1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
      repeat (3) @(negedge clk);
      pm.put(1'b0, 1'b1, 1'b0, tbl[i][22:20], tbl[i][19:12]);
      for (int r = 0; r < 2; r++) begin
        capture(c, a);
        cmp("class", {4'h0, tbl[i][11:8]}, 8'(c));
        cmp("arg", tbl[i][7:0], 8'(a));
      end
    end
  endtask

  // link flash while traffic runs, dark without it
  task automatic t_link;
    int n;
    pm.put(1'b1, 1'b1, 1'b0, 3'h0, 8'h00);
    run_len(1'b1, 1'b1, 20, n);
    cmp("link on", 8'(HALF), 8'(n));
    run_len(1'b1, 1'b0, 20, n);
    cmp("link off", 8'(HALF), 8'(n));
    pm.put(1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
    repeat (12) @(negedge clk);
    cmp("link idle", 8'h00, link);
  endtask

  // interference gives steady flashing over a pending code
  task automatic t_emc;
    int n;
    pm.put(1'b0, 1'b1, 1'b1, 3'h2, 8'h03);
    repeat (10) @(negedge clk);
    run_len(1'b0, 1'b0, 20, n); // align to the start of a lit phase
    for (int k = 0; k < 3; k++) begin
      run_len(1'b0, 1'b1, 20, n);
      cmp("emc on", 8'(HALF), 8'(n));
      run_len(1'b0, 1'b0, 20, n);
      cmp("emc off", 8'(HALF), 8'(n));
    end
    pm.put(1'b0, 1'b1, 1'b1, 3'h0, 8'h00);
    repeat (3) @(negedge clk);
    cmp("emc run", 8'h00, runl);
  endtask

  // restart drops the code, only the later fault is shown
  task automatic t_restart;
    int c, a;
    pm.put(1'b0, 1'b1, 1'b0, 3'h3, 8'h02);
    repeat (4) @(negedge clk);
    pm.rst(1'b1);
    repeat (3) @(negedge clk);
    cmp("restart dark", 8'h00, err);
    pm.put(1'b0, 1'b1, 1'b0, 3'h6, 8'h00);
    pm.rst(1'b0);
    capture(c, a);
    cmp("class after", 8'h07, 8'(c));
    cmp("arg after", 8'h00, 8'(a));
  endtask

  // reset in mid code clears every output and counter
  task automatic t_reset;
    int c, a;
    run_len(1'b0, 1'b1, 2, c); // stop inside a lit pulse
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    cmp("reset err", 8'h00, err);
    cmp("reset run", 8'h00, runl);
    cmp("reset link", 8'h00, link);
    @(posedge clk);
    rstn <= 1'b1;
    capture(c, a);
    cmp("class reset", 8'h07, 8'(c));
  endtask

  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #300000;
    n_fail++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    cmp("held err", 8'h00, err);
    rstn <= 1'b1;
    t_run();
    t_codes();
    t_link();
    t_emc();
    t_restart();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
